/* rtl/dog_timer_unit.v */
// Implementation choice: the plain strobed port.
`timescale 1ns/1ps
`include "dog_timer_defs.vh"

// Functional notes
// - Disabled and not counting after reset
// - Hidden 15-bit up-counter on slow ticks
// - Deep sleeps stop and zero counter, drop keys
// - Watchdog mode starts on enable write
// - Watchdog enable cannot be cleared
// - Mode locked once watchdog enabled
// - Interval codes: 32768, 8192, 512, 64
// - Watchdog expiry requests system reset
// - Keys 1010 then 0101 clear counter
// - Late or wrong second key: no clear
// - Sequence begun in time still clears
// - Clear field ignored while disabled
// - Interval writable while running
// - No flag or interrupt in watchdog
// - Timer mode sets flag, gated interrupt
// - Timer mode clear bit zeroes counter
// - Timer stop, restart from zero
// - Timer mode never resets system
// - Active and light sleep reset on expiry
// - First low power defers, resets on resume before next tick
module dog_timer_unit #(
    parameter CNT_WIDTH = 15,
    parameter WIN_WIDTH = 11
) (
    // Clock and reset
    input  wire       clk,
    input  wire       rstn,
    // Register port
    input  wire [7:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr_stb,
    input  wire       rd_stb,
    output reg  [7:0] rdata,
    // Low-speed oscillator tick, one cycle per period
    input  wire       osc_tick,
    // Chip power mode
    input  wire [2:0] power_mode,
    // Requests
    output reg        sys_reset_req,
    output reg        irq_req
);

    // Window length cut to the window counter on purpose
    localparam integer         KEY_WIN_INT = `KEY_WIN_CYC;
    localparam [WIN_WIDTH-1:0] KEY_WIN     = KEY_WIN_INT[WIN_WIDTH-1:0];
    localparam [WIN_WIDTH-1:0] WIN_ONE     = {{(WIN_WIDTH-1){1'b0}}, 1'b1};

    // Clear key sequence states
    localparam [0:0]           KEY_IDLE    = 1'b0;
    localparam [0:0]           KEY_ARMED   = 1'b1;

    // Control register fields
    reg                  en_r;
    reg                  en_nxt;
    reg                  mode_r;
    reg                  mode_nxt;
    reg  [1:0]           int_r;
    reg  [1:0]           int_nxt;
    reg  [3:0]           clr_r;
    reg  [3:0]           clr_nxt;

    // Interrupt flag and enable
    reg                  flag_r;
    reg                  flag_nxt;
    reg                  irq_en_r;
    reg                  irq_en_nxt;

    // Clear key window
    reg                  key_state_r;
    reg                  key_state_nxt;
    reg  [WIN_WIDTH-1:0] win_r;
    reg  [WIN_WIDTH-1:0] win_nxt;
    reg                  key_clear;
    wire                 armed = (key_state_r == KEY_ARMED);

    // Expiry held in first low power mode
    reg                  pend_r;
    reg                  pend_nxt;

    reg                  reset_nxt;
    reg  [7:0]           rdata_nxt;

    // Decode helpers
    wire ctl_wr   = wr_stb && (addr == `ADDR_DOG_CONTROL);
    wire flag_wr  = wr_stb && (addr == `ADDR_DOG_IRQ_FLAG);
    wire ien_wr   = wr_stb && (addr == `ADDR_DOG_IRQ_EN);
    wire [3:0] key = wdata[`CTL_CLR_HI:`CTL_CLR_LO];
    wire wd_lock  = en_r && (mode_r == `MODE_WATCHDOG);
    // Keys count only once enabled
    wire dog_key_wr   = ctl_wr && en_r && (mode_r == `MODE_WATCHDOG);
    wire timer_key_wr = ctl_wr && en_r && (mode_r == `MODE_TIMER);
    reg  deep;
    reg  awake;
    reg  low_one;

    // Power mode decode; spare codes count but never reset
    always @* begin
        deep    = 1'b0;
        awake   = 1'b0;
        low_one = 1'b0;
        if (power_mode == `PWR_ACTIVE || power_mode == `PWR_LIGHT) begin
            awake = 1'b1;
        end else if (power_mode == `PWR_FIRST_LOW) begin
            low_one = 1'b1;
        end else if (power_mode == `PWR_DEEP || power_mode == `PWR_DEEPEST) begin
            deep = 1'b1;
        end
    end

    // Counter control
    reg  [CNT_WIDTH-1:0] term;
    reg                  cnt_clear;
    wire                 run = en_r && !deep;
    wire                 expire;

    always @* begin
        case (int_r)
            `INT_SEL_32768: term = `TERM_32768;
            `INT_SEL_8192:  term = `TERM_8192;
            `INT_SEL_512:   term = `TERM_512;
            default:        term = `TERM_64;
        endcase
    end

    // Interval and key field writes
    always @* begin
        int_nxt = int_r;
        clr_nxt = clr_r;
        if (ctl_wr) begin
            int_nxt = wdata[`CTL_INT_HI:`CTL_INT_LO];
            if (en_r) begin
                clr_nxt = key;
            end
        end
    end

    // Mode and enable writes
    always @* begin
        en_nxt   = en_r;
        mode_nxt = mode_r;
        if (ctl_wr && !wd_lock) begin
            mode_nxt = wdata[`CTL_MODE_BIT];
            en_nxt   = wdata[`CTL_EN_BIT];
        end
    end

    always @* begin
        key_state_nxt = key_state_r;
        key_clear     = 1'b0;
        case (key_state_r)
            KEY_IDLE: begin
                if (dog_key_wr && key == `KEY_FIRST) begin
                    key_state_nxt = KEY_ARMED;
                end
            end
            KEY_ARMED: begin
                if (win_r == WIN_ONE) begin
                    key_state_nxt = KEY_IDLE;
                end
                if (dog_key_wr) begin
                    if (key == `KEY_FIRST) begin
                        // A repeated first key reopens the window
                        key_state_nxt = KEY_ARMED;
                    end else if (key == `KEY_SECOND) begin
                        key_clear     = 1'b1;
                        key_state_nxt = KEY_IDLE;
                    end else begin
                        key_state_nxt = KEY_IDLE;
                    end
                end
            end
        endcase
        // deep sleeps drop a half-done sequence
        if (deep) begin
            key_state_nxt = KEY_IDLE;
        end
    end

    // Key window countdown
    always @* begin
        win_nxt = win_r;
        if (armed) begin
            win_nxt = win_r - WIN_ONE;
        end
        if (dog_key_wr && key == `KEY_FIRST) begin
            win_nxt = KEY_WIN;
        end
    end

    // Counter clear sources
    always @* begin
        cnt_clear = key_clear;
        if (timer_key_wr && key[`CLR_TIMER_BIT]) begin
            cnt_clear = 1'b1;
        end
        if (!en_r && en_nxt) begin
            cnt_clear = 1'b1;
        end
        if (deep) begin
            cnt_clear = 1'b1;
        end
    end

    dog_interval_counter #(
        .WIDTH (CNT_WIDTH)
    ) u_counter (
        .clk    (clk),
        .rstn   (rstn),
        .tick   (osc_tick),
        .run    (run),
        .clear  (cnt_clear),
        .term   (term),
        .expire (expire)
    );

    // Interrupt enable bit
    always @* begin
        irq_en_nxt = irq_en_r;
        if (ien_wr) begin
            irq_en_nxt = wdata[`IRQ_BIT];
        end
    end

    // Interrupt flag; a set in the same cycle beats a clear
    always @* begin
        flag_nxt = flag_r;
        // Write one clears
        if (flag_wr && wdata[`IRQ_BIT]) begin
            flag_nxt = 1'b0;
        end
        if (expire && mode_r == `MODE_TIMER) begin
            flag_nxt = 1'b1;
        end
    end

    // Expiry held in first low power mode
    always @* begin
        pend_nxt = pend_r;
        // Held expiry lapses at next slow tick
        if (osc_tick || cnt_clear) begin
            pend_nxt = 1'b0;
        end
        // hold off in first low power
        if (expire && mode_r == `MODE_WATCHDOG && low_one) begin
            pend_nxt = 1'b1;
        end
    end

    // System reset request, held until chip reset
    always @* begin
        reset_nxt = sys_reset_req;
        if (expire && mode_r == `MODE_WATCHDOG && awake) begin
            reset_nxt = 1'b1;
        end
        if (pend_r && awake) begin
            reset_nxt = 1'b1;
        end
    end

    // Read mux, data valid one cycle later
    always @* begin
        rdata_nxt = 8'h00;
        if (rd_stb) begin
            if (addr == `ADDR_DOG_CONTROL) begin
                rdata_nxt[`CTL_CLR_HI:`CTL_CLR_LO] = clr_r;
                rdata_nxt[`CTL_EN_BIT]             = en_r;
                rdata_nxt[`CTL_MODE_BIT]           = mode_r;
                rdata_nxt[`CTL_INT_HI:`CTL_INT_LO] = int_r;
            end else if (addr == `ADDR_DOG_IRQ_FLAG) begin
                rdata_nxt[`IRQ_BIT] = flag_r;
            end else if (addr == `ADDR_DOG_IRQ_EN) begin
                rdata_nxt[`IRQ_BIT] = irq_en_r;
            end else if (addr == `ADDR_DOG_STATUS) begin
                rdata_nxt[`STS_PEND_BIT]  = pend_r;
                rdata_nxt[`STS_ARMED_BIT] = armed;
                rdata_nxt[`STS_LOCK_BIT]  = wd_lock;
                rdata_nxt[`STS_RUN_BIT]   = run;
            end
        end
    end

    // all state on one clock, ticks as enables
    always @(posedge clk) begin
        if (!rstn) begin
            en_r          <= 1'b0;
            mode_r        <= `MODE_WATCHDOG;
            int_r         <= `INT_SEL_32768;
            clr_r         <= 4'h0;
            flag_r        <= 1'b0;
            irq_en_r      <= 1'b0;
            key_state_r   <= KEY_IDLE;
            win_r         <= {WIN_WIDTH{1'b0}};
            pend_r        <= 1'b0;
        end else begin
            en_r          <= en_nxt;
            mode_r        <= mode_nxt;
            int_r         <= int_nxt;
            clr_r         <= clr_nxt;
            flag_r        <= flag_nxt;
            irq_en_r      <= irq_en_nxt;
            key_state_r   <= key_state_nxt;
            win_r         <= win_nxt;
            pend_r        <= pend_nxt;
        end
    end

    // Outputs straight from flops
    always @(posedge clk) begin
        if (!rstn) begin
            sys_reset_req <= 1'b0;
            irq_req       <= 1'b0;
            rdata         <= 8'h00;
        end else begin
            sys_reset_req <= reset_nxt;
            irq_req       <= flag_nxt && irq_en_nxt;
            rdata         <= rdata_nxt;
        end
    end

endmodule

/* include/dog_timer_defs.vh */
`ifndef DOG_TIMER_DEFS_VH
`define DOG_TIMER_DEFS_VH

// Register addresses
`define ADDR_DOG_CONTROL   8'hC9
`define ADDR_DOG_IRQ_FLAG  8'hCA
`define ADDR_DOG_IRQ_EN    8'hCB
`define ADDR_DOG_STATUS    8'hCC

// Control register fields
`define CTL_CLR_HI         7
`define CTL_CLR_LO         4
`define CTL_EN_BIT         3
`define CTL_MODE_BIT       2
`define CTL_INT_HI         1
`define CTL_INT_LO         0
`define CTL_RESET          8'h00

// Single-bit flag and enable registers
`define IRQ_BIT            0

// Timer mode clear bit within the key field
`define CLR_TIMER_BIT      0

// Status register fields
`define STS_RUN_BIT        0
`define STS_LOCK_BIT       1
`define STS_ARMED_BIT      2
`define STS_PEND_BIT       3

// Mode bit values
`define MODE_WATCHDOG      1'b0
`define MODE_TIMER         1'b1

// Clear keys
`define KEY_FIRST          4'hA
`define KEY_SECOND         4'h5

// Interval select codes and terminal counts
`define INT_SEL_32768      2'h0
`define INT_SEL_8192       2'h1
`define INT_SEL_512        2'h2
`define INT_SEL_64         2'h3
`define TERM_32768         15'h7FFF
`define TERM_8192          15'h1FFF
`define TERM_512           15'h01FF
`define TERM_64            15'h003F

// Power modes
`define PWR_ACTIVE         3'h0
`define PWR_LIGHT          3'h1
`define PWR_FIRST_LOW      3'h2
`define PWR_DEEP           3'h3
`define PWR_DEEPEST        3'h4

// Timing
`define CLK_PERIOD_NS      10
`define HALF_WDCLK_NS      15258
`define KEY_WIN_CYC        (`HALF_WDCLK_NS / `CLK_PERIOD_NS)

`endif

/* rtl/dog_interval_counter.v */
`timescale 1ns/1ps
`include "dog_timer_defs.vh"

module dog_interval_counter #(
    parameter WIDTH = 15
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rstn,
    // Control
    input  wire             tick,
    input  wire             run,
    input  wire             clear,
    input  wire [WIDTH-1:0] term,
    // Result
    output wire             expire
);

    reg  [WIDTH-1:0] count_r;
    reg  [WIDTH-1:0] count_nxt;

    // Count is invisible to software on purpose
    assign expire = run & tick & (count_r == term);

    always @* begin
        count_nxt = count_r;
        if (clear || expire) begin
            count_nxt = {WIDTH{1'b0}};
        end else if (run && tick) begin
            count_nxt = count_r + {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk) begin
        if (!rstn) begin
            count_r <= {WIDTH{1'b0}};
        end else begin
            count_r <= count_nxt;
        end
    end

endmodule

/* testbench/dog_timer_props.sv */
`timescale 1ns/1ps
`include "dog_timer_defs.vh"

module dog_timer_props (
    // Clock and reset
    input wire       clk,
    input wire       rstn,
    // Register port
    input wire [7:0] addr,
    input wire [7:0] wdata,
    input wire       wr_stb,
    input wire       rd_stb,
    input wire [7:0] rdata,
    // Slow tick and power
    input wire       osc_tick,
    input wire [2:0] power_mode,
    // Requests
    input wire       sys_reset_req,
    input wire       irq_req
);
    reg [6:0] tick_cnt_r;
    reg       ien_r;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Saturates, only the shortest interval matters
    always @(posedge clk) begin
        if (!rstn) begin
            tick_cnt_r <= 7'h00;
            ien_r <= 1'b0;
        end else begin
            if (osc_tick && tick_cnt_r != 7'h7F)
                tick_cnt_r <= tick_cnt_r + 7'h01;
            if (wr_stb && addr == `ADDR_DOG_IRQ_EN)
                ien_r <= wdata[0];
        end
    end

    a_rdata_quiet: assert property (!rd_stb |=> rdata == 8'h00) // hidden count
        else $error("read data outside read slot");
    a_rd_unmapped: assert property (rd_stb && (addr < 8'hC9 || addr > 8'hCC) |=> rdata == 8'h00) // hidden
        else $error("unmapped read not zero");
    a_reset_latched: assert property (sys_reset_req |=> sys_reset_req) // sticky
        else $error("reset request dropped");
    a_reset_awake: assert property ($rose(sys_reset_req) |-> // awake only
        $past(power_mode) == `PWR_ACTIVE || $past(power_mode) == `PWR_LIGHT)
        else $error("reset raised while asleep");
    a_reset_min: assert property ($rose(sys_reset_req) |-> tick_cnt_r >= 7'h40) // shortest
        else $error("reset before shortest interval");
    a_irq_cause: assert property ($rose(irq_req) |-> $past(osc_tick) || $past(osc_tick, 2) // flag cause
        || $past(osc_tick, 3) || $past(wr_stb) || $past(wr_stb, 2))
        else $error("interrupt without tick or write");
    a_irq_drop: assert property ($fell(irq_req) |-> $past(wr_stb) || $past(wr_stb, 2)) // software
        else $error("interrupt dropped by itself");
    a_irq_gated: assert property (irq_req |-> ien_r || $past(ien_r)) // gating
        else $error("interrupt while disabled");

    c_reset: cover property ($rose(sys_reset_req));
    c_irq: cover property ($rose(irq_req));
    c_unmapped: cover property (rd_stb && addr == 8'hC0);
endmodule

/* testbench/testbench.sv */
`timescale 1ns/1ps
`include "dog_timer_defs.vh"

module testbench;
    reg        clk;
    reg        rstn;
    reg  [7:0] addr;
    reg  [7:0] wdata;
    reg        wr_stb;
    reg        rd_stb;
    reg        osc_tick;
    reg  [2:0] power_mode;
    wire [7:0] rdata;
    wire       sys_reset_req;
    wire       irq_req;
    integer    fail_count;
    integer    num_checks;
    integer    cyc;

    dog_timer_unit i_dog_timer_unit (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .osc_tick(osc_tick),
        .power_mode(power_mode), .sys_reset_req(sys_reset_req), .irq_req(irq_req));

    task stop_test;
        if (fail_count == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task chk(input [7:0] seen, input [7:0] exp);
        num_checks = num_checks + 1;
        if (seen !== exp) begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            fail_count = fail_count + 1;
        end
    endtask

    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk) begin wr_stb <= 1'b1; addr <= a; wdata <= d; end
        @(posedge clk) wr_stb <= 1'b0;
    endtask

    task rd(input [7:0] a, input [7:0] e);
        @(posedge clk) begin rd_stb <= 1'b1; addr <= a; end
        @(posedge clk) rd_stb <= 1'b0;
        #1 chk(rdata, e);
    endtask

    task tick(input integer n);
        integer i;
        for (i = 0; i < n; i = i + 1) begin
            @(posedge clk) osc_tick <= 1'b1;
            @(posedge clk) osc_tick <= 1'b0;
        end
    endtask

    task settle;
        repeat (3) @(posedge clk);
        #1;
    endtask

    task do_reset;
        @(posedge clk) rstn <= 1'b0;
        repeat (2) @(posedge clk);
        rstn <= 1'b1;
    endtask

    task s_regs;
        rd(`ADDR_DOG_CONTROL, 8'h00);
        rd(8'hC0, 8'h00);
        wr(`ADDR_DOG_CONTROL, 8'hA0);
        rd(`ADDR_DOG_CONTROL, 8'h00);
        tick(100);
        settle;
        chk(sys_reset_req, 1'b0);
    endtask

    task s_timer;
        integer k;
        integer n;
        wr(`ADDR_DOG_IRQ_EN, 8'h01);
        // Longest interval must outlast the next shorter one
        wr(`ADDR_DOG_CONTROL, 8'h0C);
        tick(8192);
        settle;
        chk(irq_req, 1'b0);
        wr(`ADDR_DOG_CONTROL, 8'h04);
        for (k = 1; k < 4; k = k + 1) begin
            n = (k == 1) ? 8192 : (k == 2) ? 512 : 64;
            wr(`ADDR_DOG_CONTROL, 8'h0C | k[7:0]);
            tick(n - 1);
            settle;
            chk(irq_req, 1'b0);
            tick(1);
            settle;
            chk(irq_req, 1'b1);
            chk(sys_reset_req, 1'b0);
            wr(`ADDR_DOG_IRQ_FLAG, 8'h01);
            settle;
            chk(irq_req, 1'b0);
            tick(n);
            settle;
            chk(irq_req, 1'b1);
            wr(`ADDR_DOG_IRQ_FLAG, 8'h01);
        end
        tick(40);
        wr(`ADDR_DOG_CONTROL, 8'h1F);
        tick(40);
        settle;
        chk(irq_req, 1'b0);
        tick(24);
        settle;
        chk(irq_req, 1'b1);
        wr(`ADDR_DOG_IRQ_FLAG, 8'h01);
        // Leave a partial count so a restart must zero it
        tick(30);
        wr(`ADDR_DOG_CONTROL, 8'h07);
        tick(100);
        settle;
        chk(irq_req, 1'b0);
        wr(`ADDR_DOG_CONTROL, 8'h0F);
        tick(63);
        settle;
        chk(irq_req, 1'b0);
        tick(1);
        settle;
        chk(irq_req, 1'b1);
        wr(`ADDR_DOG_IRQ_EN, 8'h00);
        wr(`ADDR_DOG_IRQ_FLAG, 8'h01);
        tick(64);
        settle;
        chk(irq_req, 1'b0);
        rd(`ADDR_DOG_IRQ_FLAG, 8'h01);
        wr(`ADDR_DOG_IRQ_EN, 8'h01);
        settle;
        chk(irq_req, 1'b1);
        chk(sys_reset_req, 1'b0);
    endtask

    task s_dog;
        wr(`ADDR_DOG_IRQ_EN, 8'h01);
        wr(`ADDR_DOG_CONTROL, 8'h0B);
        wr(`ADDR_DOG_CONTROL, 8'h07);
        rd(`ADDR_DOG_CONTROL, 8'h0B);
        rd(`ADDR_DOG_STATUS, 8'h03);
        tick(60);
        wr(`ADDR_DOG_CONTROL, 8'hAB);
        wr(`ADDR_DOG_CONTROL, 8'h5B);
        tick(60);
        settle;
        chk(sys_reset_req, 1'b0);
        @(posedge clk) power_mode <= `PWR_DEEP;
        tick(50);
        power_mode <= `PWR_DEEPEST;
        tick(50);
        power_mode <= `PWR_LIGHT;
        tick(63);
        settle;
        chk(sys_reset_req, 1'b0);
        // Second key arrives just past the half slow period
        wr(`ADDR_DOG_CONTROL, 8'hAB);
        repeat (1600) @(posedge clk);
        wr(`ADDR_DOG_CONTROL, 8'h5B);
        tick(1);
        settle;
        chk(sys_reset_req, 1'b1);
        chk(irq_req, 1'b0);
    endtask

    task s_first_low;
        wr(`ADDR_DOG_CONTROL, 8'h0B);
        power_mode <= `PWR_FIRST_LOW;
        tick(64);
        settle;
        chk(sys_reset_req, 1'b0);
        @(posedge clk) power_mode <= `PWR_ACTIVE;
        settle;
        chk(sys_reset_req, 1'b1);
    endtask

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Whole run needs about 55k cycles
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end

    initial begin
        cyc = 0;
        fail_count = 0;
        num_checks = 0;
        rstn = 1'b0;
        addr = 8'h00;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
        osc_tick = 1'b0;
        power_mode = `PWR_ACTIVE;
        do_reset;
        s_regs;
        s_timer;
        do_reset;
        s_dog;
        do_reset;
        s_first_low;
        stop_test;
    end
endmodule

bind dog_timer_unit dog_timer_props i_dog_timer_props (.clk(clk), .rstn(rstn), .addr(addr),
    .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .osc_tick(osc_tick),
    .power_mode(power_mode), .sys_reset_req(sys_reset_req), .irq_req(irq_req));
